/* pmwc_pkg.sv */
// Purpose: Shared constants and carrier types for the power mode and wake-up controller.
// Assumes: Single 25 MHz clock domain; all control bits arrive as plain ports.
// Notes:   No register bus; software-facing bits are ports of the top module.
package pmwc_pkg;
   // ============================================================
   // Field widths and encodings
   localparam int          PMWC_NPINS       = 8;
   localparam int          PMWC_NIRQ        = 8;
   localparam logic [2:0]  PMWC_CKS_SLOW    = 3'h7;
   localparam logic [2:0]  PMWC_CKS_DIV64   = 3'h6;
   localparam logic [1:0]  PMWC_EDGE_NONE   = 2'h0;
   localparam logic [1:0]  PMWC_EDGE_RISE   = 2'h1;
   localparam logic [1:0]  PMWC_EDGE_FALL   = 2'h2;
   localparam logic [1:0]  PMWC_EDGE_BOTH   = 2'h3;
   localparam logic [6:0]  PMWC_DIV_MAX     = 7'h7F;
   localparam logic [6:0]  PMWC_DIV_ZERO    = 7'h00;
   // PLL settle time in ns, rounded up to the block's own clock cycles.
   localparam int          PMWC_PLL_SETTLE_NS  = 1000;
   localparam int          PMWC_CLK_NS         = 40;
   localparam logic [7:0]  PMWC_PLL_SETTLE_CYC =
      8'((PMWC_PLL_SETTLE_NS + PMWC_CLK_NS - 1) / PMWC_CLK_NS);

   // ============================================================
   // Carrier types
   typedef struct packed {
      logic [2:0] clock_select_field;
      logic       high_clock_idle_keep;
      logic       sub_clock_idle_keep;
      logic       sub_clock_source_select;
   } pmwc_scc_t;

   typedef struct packed {
      logic run_gate;
      logic high_gate;
      logic sub_gate;
      logic slow_sel;
   } pmwc_gate_t;

   typedef enum logic [2:0] {
      PMWC_WAKE_NONE,
      PMWC_WAKE_SYS_RESET,
      PMWC_WAKE_WDT_RESET,
      PMWC_WAKE_RESUME,
      PMWC_WAKE_SERVICE
   } pmwc_wake_t;
endpackage

/* pmwc_ctrl.sv */
// Purpose: Operating-mode controller: clock select, halt modes, flags and wake-up.
// Assumes: CPU core gives one-cycle pulses for halt and clear-watchdog; pins are async.
// Notes:   Clock gating outputs are enables for an external glitch-free clock gate.
module pmwc_ctrl
   import pmwc_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   input  wire pmwc_scc_t            scc_in,
   input  wire logic                 halt_in,
   input  wire logic                 clr_wdt_in,
   input  wire logic                 wdt_enable_in,
   input  wire logic                 wdt_overflow_in,
   input  wire logic                 usb_enable_in,
   input  wire logic                 pin_reset_n_in,
   input  wire logic                 usb_reset_in,
   input  wire logic [PMWC_NPINS-1:0] port_pins_in,
   input  wire logic [PMWC_NPINS-1:0] port_a_wake_edge_low,
   input  wire logic [PMWC_NPINS-1:0] port_a_wake_edge_high,
   input  wire logic [PMWC_NIRQ-1:0] irq_req_in,
   input  wire logic [PMWC_NIRQ-1:0] irq_enable_in,
   input  wire logic                 stack_full_in,
   input  wire logic                 low_crystal_osc_stable_in,
   input  wire logic                 low_internal_rc_stable_in,
   input  wire logic                 pll_enable_in,
   output logic                      pmwc_gate_valid_out,
   output pmwc_gate_t                gate_out,
   output logic [6:0]                high_div_mask_out,
   output logic                      power_down_flag_out,
   output logic                      wdt_expiry_flag_out,
   output logic                      wdt_clear_out,
   output logic                      wdt_run_out,
   output logic                      usb_suspend_out,
   output logic                      pll_lock_flag_out,
   output pmwc_wake_t                wake_cause_out,
   output logic                      sys_reset_out,
   output logic                      wdt_reset_out,
   output logic                      irq_service_out,
   output logic                      low_power_out
);

   // ============================================================
   // Synchronisers for asynchronous pin inputs
   // Pin history resets low, so a pin idling high shows one rising edge after reset.
   // Such an edge only matters in low power, which reset never enters directly.
   logic [PMWC_NPINS-1:0] pin_s1_r;
   logic [PMWC_NPINS-1:0] pin_s2_r;
   logic [PMWC_NPINS-1:0] pin_prev_r;
   logic [1:0]            rst_s_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_s1_r   <= '0;
         pin_s2_r   <= '0;
         pin_prev_r <= '0;
         rst_s_r    <= '1;
      end else begin
         pin_s1_r   <= port_pins_in;
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
         rst_s_r    <= {rst_s_r[0], pin_reset_n_in};
      end
   end

   // ============================================================
   // Per-pin edge detection with selectable trigger edge
   logic [PMWC_NPINS-1:0] pin_hit;

   // A cleared edge select turns the pin's wake-up off.
   for (genvar i = 0; i < PMWC_NPINS; i++) begin : g_pin
      logic [1:0] sel;
      assign sel = {port_a_wake_edge_high[i], port_a_wake_edge_low[i]};
      always_comb begin
         case (sel)
            PMWC_EDGE_RISE: pin_hit[i] = pin_s2_r[i] & ~pin_prev_r[i];
            PMWC_EDGE_FALL: pin_hit[i] = ~pin_s2_r[i] & pin_prev_r[i];
            PMWC_EDGE_BOTH: pin_hit[i] = pin_s2_r[i] ^ pin_prev_r[i];
            default:        pin_hit[i] = 1'b0;
         endcase
      end
   end

   // ============================================================
   // Mode state machine
   typedef enum logic [2:0] {
      PMWC_ST_NORMAL,
      PMWC_ST_SLOW,
      PMWC_ST_SLEEP,
      PMWC_ST_IDLE_SUB,
      PMWC_ST_IDLE_BOTH,
      PMWC_ST_IDLE_HIGH
   } pmwc_state_t;

   pmwc_state_t           state_r;
   pmwc_state_t           state_nxt;
   logic [PMWC_NIRQ-1:0]  irq_armed_r;
   logic                  sub_stable;
   logic                  want_slow;
   logic                  in_lp;
   logic [PMWC_NIRQ-1:0]  irq_wake;
   logic                  pin_rst_wake;
   logic                  irq_any;
   logic                  irq_svc;
   pmwc_wake_t            cause;

   // Leaving SLOW needs no stable check here; software watches the high
   // oscillator and PLL flags before relying on the faster clock.
   assign sub_stable = scc_in.sub_clock_source_select ? low_crystal_osc_stable_in
                                                      : low_internal_rc_stable_in;
   assign want_slow  = (scc_in.clock_select_field == PMWC_CKS_SLOW);
   assign in_lp      = (state_r == PMWC_ST_SLEEP) || (state_r == PMWC_ST_IDLE_SUB) ||
                       (state_r == PMWC_ST_IDLE_BOTH) || (state_r == PMWC_ST_IDLE_HIGH);
   assign irq_wake   = irq_req_in & irq_armed_r;
   assign irq_any    = |irq_wake;
   assign irq_svc    = |(irq_wake & irq_enable_in) & ~stack_full_in;
   assign pin_rst_wake = ~rst_s_r[1];

   // Only the second flop of each synchroniser and the pin history flop feed the wake decision.
   // Wake priority: resets first, then watchdog, then interrupts, then pins.
   always_comb begin
      cause = PMWC_WAKE_NONE;
      if (in_lp) begin
         if (pin_rst_wake || usb_reset_in) begin
            cause = PMWC_WAKE_SYS_RESET;
         end else if (wdt_overflow_in) begin
            cause = PMWC_WAKE_WDT_RESET;
         end else if (irq_any && irq_svc) begin
            cause = PMWC_WAKE_SERVICE;
         end else if (irq_any || (|pin_hit)) begin
            cause = PMWC_WAKE_RESUME;
         end
      end
   end

   // Halt is taken only from a running mode; a halt seen in low power is ignored.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PMWC_ST_NORMAL, PMWC_ST_SLOW: begin
            if (halt_in) begin
               case ({scc_in.high_clock_idle_keep, scc_in.sub_clock_idle_keep})
                  2'h0:    state_nxt = PMWC_ST_SLEEP;
                  2'h1:    state_nxt = PMWC_ST_IDLE_SUB;
                  2'h3:    state_nxt = PMWC_ST_IDLE_BOTH;
                  default: state_nxt = PMWC_ST_IDLE_HIGH;
               endcase
            end else if (want_slow && sub_stable) begin
               state_nxt = PMWC_ST_SLOW;
            end else if (!want_slow) begin
               state_nxt = PMWC_ST_NORMAL;
            end
         end
         PMWC_ST_SLEEP, PMWC_ST_IDLE_SUB, PMWC_ST_IDLE_BOTH, PMWC_ST_IDLE_HIGH: begin
            if (cause != PMWC_WAKE_NONE) begin
               state_nxt = (want_slow && sub_stable) ? PMWC_ST_SLOW : PMWC_ST_NORMAL;
            end
         end
         default: state_nxt = PMWC_ST_NORMAL;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= PMWC_ST_NORMAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Interrupts pending at halt are disarmed as wake sources for this stay.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_armed_r <= '0;
      end else if (halt_in && !in_lp) begin
         irq_armed_r <= ~irq_req_in;
      end
   end

   // ============================================================
   // Clock gating and divider selection
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         gate_out            <= '{run_gate: 1'b1, high_gate: 1'b1, sub_gate: 1'b1,
                                  slow_sel: 1'b0};
         pmwc_gate_valid_out <= 1'b0;
         high_div_mask_out   <= PMWC_DIV_ZERO;
         low_power_out       <= 1'b0;
      end else begin
         pmwc_gate_valid_out <= 1'b1;
         low_power_out       <= (state_nxt != PMWC_ST_NORMAL) && (state_nxt != PMWC_ST_SLOW);
         gate_out.slow_sel   <= (state_nxt == PMWC_ST_SLOW);
         // Execution gate drops in every low-power mode; state is simply held.
         gate_out.run_gate   <= (state_nxt == PMWC_ST_NORMAL) ||
                                (state_nxt == PMWC_ST_SLOW);
         gate_out.high_gate  <= (state_nxt == PMWC_ST_NORMAL) ||
                                (state_nxt == PMWC_ST_IDLE_BOTH) ||
                                (state_nxt == PMWC_ST_IDLE_HIGH);
         gate_out.sub_gate   <= (state_nxt == PMWC_ST_SLOW) ||
                                (state_nxt == PMWC_ST_NORMAL) ||
                                (state_nxt == PMWC_ST_IDLE_SUB) ||
                                (state_nxt == PMWC_ST_IDLE_BOTH);
         // Divide by 2^n: mask of counter bits that must be all ones per tick.
         // Field 111 holds the mask; it is only read while a divided rate is selected.
         if (scc_in.clock_select_field <= PMWC_CKS_DIV64) begin
            high_div_mask_out <= PMWC_DIV_MAX >>
                                 (PMWC_CKS_SLOW - scc_in.clock_select_field);
         end
      end
   end

   // ============================================================
   // Status flags
   // Halt entry wins over clear-watchdog in the same cycle.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_down_flag_out <= 1'b0;
      end else if (halt_in && !in_lp) begin
         power_down_flag_out <= 1'b1;
      end else if (clr_wdt_in) begin
         power_down_flag_out <= 1'b0;
      end
   end

   // A watchdog overflow wins over the halt clear in the same cycle.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wdt_expiry_flag_out <= 1'b0;
      end else if (wdt_overflow_in) begin
         wdt_expiry_flag_out <= 1'b1;
      end else if (halt_in && !in_lp) begin
         wdt_expiry_flag_out <= 1'b0;
      end
   end

   // ============================================================
   // Watchdog, USB and wake outputs
   // Clear pulses reach the watchdog counter one cycle after halt or clear.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wdt_clear_out   <= 1'b0;
         wdt_run_out     <= 1'b0;
         usb_suspend_out <= 1'b0;
         wake_cause_out  <= PMWC_WAKE_NONE;
         sys_reset_out   <= 1'b0;
         wdt_reset_out   <= 1'b0;
         irq_service_out <= 1'b0;
      end else begin
         wdt_clear_out   <= (halt_in && !in_lp) || clr_wdt_in;
         wdt_run_out     <= wdt_enable_in;
         usb_suspend_out <= usb_enable_in && ((state_nxt == PMWC_ST_SLEEP) ||
                                              (state_nxt == PMWC_ST_IDLE_SUB));
         wake_cause_out  <= cause;
         sys_reset_out   <= (cause == PMWC_WAKE_SYS_RESET);
         // Only PC and SP are reset by the core on this pulse.
         wdt_reset_out   <= (cause == PMWC_WAKE_WDT_RESET);
         irq_service_out <= (cause == PMWC_WAKE_SERVICE);
      end
   end

   // ============================================================
   // PLL lock flag: low on enable, high after settle time
   // The settle count is rounded up to whole cycles of the block clock.
   // The counter stops at that count and the flag stays high until the
   // enable drops, which clears both.
   logic [7:0] pll_cnt_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pll_cnt_r         <= '0;
         pll_lock_flag_out <= 1'b0;
      end else if (!pll_enable_in) begin
         pll_cnt_r         <= '0;
         pll_lock_flag_out <= 1'b0;
      end else if (pll_cnt_r != PMWC_PLL_SETTLE_CYC) begin
         pll_cnt_r         <= pll_cnt_r + 8'h01;
         pll_lock_flag_out <= 1'b0;
      end else begin
         pll_lock_flag_out <= 1'b1;
      end
   end

endmodule

/* pmwc_ctrl_sva.sv */
// Purpose: Concurrent checks on the mode controller's ports.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound to every instance of the controller.
module pmwc_ctrl_sva
   import pmwc_pkg::*;
(
   input wire logic       clk_in,
   input wire logic       arst_n_in,
   input wire pmwc_scc_t  scc_in,
   input wire logic       halt_in,
   input wire logic       clr_wdt_in,
   input wire logic       wdt_overflow_in,
   input wire logic       usb_enable_in,
   input wire logic       usb_reset_in,
   input logic            low_power_out,
   input pmwc_gate_t      gate_out,
   input logic            power_down_flag_out,
   input logic            wdt_expiry_flag_out,
   input logic            wdt_clear_out,
   input logic            usb_suspend_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);
   logic       enter;
   logic [1:0] keep;
   assign enter = halt_in && !low_power_out;
   assign keep = {scc_in.high_clock_idle_keep, scc_in.sub_clock_idle_keep};
   // ============================================================
   // Halt entry and clear-watchdog
   a_halt_sets_flags: assert property (enter |=> power_down_flag_out && wdt_clear_out
      && low_power_out) else $error("halt entry flags wrong");
   a_halt_clears_to: assert property (enter && !wdt_overflow_in |=> !wdt_expiry_flag_out)
      else $error("expiry flag not cleared by halt");
   a_sleep_gates_off: assert property (enter && keep == 2'h0 |=>
      !gate_out.run_gate && !gate_out.high_gate && !gate_out.sub_gate) else $error("sleep gates");
   a_idle_sub_gates: assert property (enter && keep == 2'h1 |=>
      !gate_out.run_gate && !gate_out.high_gate && gate_out.sub_gate) else $error("idle sub gates");
   a_idle_both_gates: assert property (enter && keep == 2'h3 |=>
      !gate_out.run_gate && gate_out.high_gate && gate_out.sub_gate) else $error("idle both gates");
   a_idle_high_gates: assert property (enter && keep == 2'h2 |=>
      !gate_out.run_gate && gate_out.high_gate && !gate_out.sub_gate) else $error("idle high gates");
   a_usb_suspend_entry: assert property (enter && !keep[1] |=>
      usb_suspend_out == $past(usb_enable_in)) else $error("usb suspend wrong");
   a_clrwdt_clears_pdf: assert property (clr_wdt_in && !halt_in && !low_power_out
      |=> !power_down_flag_out) else $error("power-down flag not cleared");
   // ============================================================
   // Low power and wake-up
   a_lp_no_run: assert property (low_power_out |-> !gate_out.run_gate)
      else $error("execution clock runs in low power");
   a_wdt_wake_flag: assert property (low_power_out && wdt_overflow_in && !usb_reset_in
      |-> ##[1:2] wdt_expiry_flag_out) else $error("expiry flag not set on watchdog wake");
endmodule
bind pmwc_ctrl pmwc_ctrl_sva u_sva (.clk_in, .arst_n_in, .scc_in, .halt_in, .clr_wdt_in,
   .wdt_overflow_in, .usb_enable_in, .usb_reset_in, .low_power_out, .gate_out,
   .power_down_flag_out, .wdt_expiry_flag_out, .wdt_clear_out, .usb_suspend_out);

/* pmwc_ctrl_test.sv */
// Purpose: Self-checking bench for the power mode and wake-up controller.
// Assumes: Inputs change on the rising edge; outputs are sampled on the falling edge.
// Notes:   Each halt scenario wakes by one cause and checks it; clock select and PLL lock are checked last.
module pmwc_ctrl_test
   import pmwc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, arst_n_in = 0, halt_in = 0, clr_wdt_in = 0, wdt_enable_in = 1;
   logic wdt_overflow_in = 0, usb_enable_in = 1, pin_reset_n_in = 1, usb_reset_in = 0;
   logic stack_full_in = 0, low_crystal_osc_stable_in = 0, low_internal_rc_stable_in = 1;
   logic pll_enable_in = 0;
   pmwc_scc_t  scc_in = '0;
   logic [7:0] port_pins_in = 8'h00, port_a_wake_edge_low = 8'h00;
   logic [7:0] port_a_wake_edge_high = 8'h00, irq_req_in = 8'h00, irq_enable_in = 8'hFF;
   logic pmwc_gate_valid_out, power_down_flag_out, wdt_expiry_flag_out, wdt_clear_out;
   logic wdt_run_out, usb_suspend_out, pll_lock_flag_out, sys_reset_out, wdt_reset_out;
   logic irq_service_out, low_power_out;
   logic [6:0] high_div_mask_out;
   pmwc_gate_t gate_out;
   pmwc_wake_t wake_cause_out, cause;
   logic       svc, wrst, srst;
   int         errors = 0, checked = 0;

   pmwc_ctrl DUT (.clk_in, .arst_n_in, .scc_in, .halt_in, .clr_wdt_in, .wdt_enable_in,
      .wdt_overflow_in, .usb_enable_in, .pin_reset_n_in, .usb_reset_in, .port_pins_in,
      .port_a_wake_edge_low, .port_a_wake_edge_high, .irq_req_in, .irq_enable_in,
      .stack_full_in, .low_crystal_osc_stable_in, .low_internal_rc_stable_in, .pll_enable_in,
      .pmwc_gate_valid_out, .gate_out, .high_div_mask_out, .power_down_flag_out,
      .wdt_expiry_flag_out, .wdt_clear_out, .wdt_run_out, .usb_suspend_out, .pll_lock_flag_out,
      .wake_cause_out, .sys_reset_out, .wdt_reset_out, .irq_service_out, .low_power_out);

   always #20 clk_in = ~clk_in;

   // ============================================================
   // Shared tasks
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task final_report;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task halt(input logic [1:0] keep);
      @(posedge clk_in);
      scc_in.high_clock_idle_keep <= keep[1];
      scc_in.sub_clock_idle_keep <= keep[0];
      halt_in <= 1'b1;
      @(posedge clk_in);
      halt_in <= 1'b0;
      @(negedge clk_in);
   endtask

   // Collects wake pulses until low power ends or the limit runs out.
   task wake(input int lim);
      int n;
      n = 0;
      cause = PMWC_WAKE_NONE;
      {svc, wrst, srst} = 3'h0;
      while (n < lim && low_power_out !== 1'b0) begin
         @(negedge clk_in);
         n++;
         if (wake_cause_out !== PMWC_WAKE_NONE) cause = wake_cause_out;
         if (irq_service_out === 1'b1) svc = 1'b1;
         if (wdt_reset_out === 1'b1) wrst = 1'b1;
         if (sys_reset_out === 1'b1) srst = 1'b1;
      end
   endtask

   initial begin
      #(40 * 3000);
      errors++;
      final_report;
   end

   // ============================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(negedge clk_in);
      chk(8'(gate_out), 8'h0E);
      chk(8'({power_down_flag_out, low_power_out, pmwc_gate_valid_out}), 8'h01);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_in);
         wdt_enable_in <= !k[0];
         halt(k[1:0]);
         chk(8'(gate_out), {5'h00, k[1:0], 1'b0});
         chk(8'({power_down_flag_out, wdt_expiry_flag_out, low_power_out}), 8'h05);
         chk(8'(usb_suspend_out), 8'(!k[1]));
         chk(8'({wdt_clear_out, wdt_run_out}), {6'h00, 1'b1, !k[0]});
         @(posedge clk_in);
         irq_req_in <= 8'h01;
         wake(10);
         chk({svc, 4'h0, cause}, {1'b1, 4'h0, PMWC_WAKE_SERVICE});
         chk(8'(gate_out), 8'h0E);
         @(posedge clk_in);
         irq_req_in <= 8'h00;
      end
      for (int k = 0; k < 2; k++) begin
         irq_enable_in <= k ? 8'hFF : 8'hFE;
         stack_full_in <= k[0];
         halt(2'h0);
         @(posedge clk_in);
         irq_req_in <= 8'h01;
         wake(10);
         chk({svc, 4'h0, cause}, {1'b0, 4'h0, PMWC_WAKE_RESUME});
         @(posedge clk_in);
         irq_req_in <= 8'h00;
      end
      {wdt_enable_in, irq_enable_in, stack_full_in} <= {1'b1, 8'hFF, 1'b0};
      for (int e = 1; e < 4; e++) begin
         port_a_wake_edge_low <= {7'h00, e[0]};
         port_a_wake_edge_high <= {7'h00, e[1]};
         port_pins_in <= (e == 2) ? 8'h01 : 8'h00;
         irq_req_in <= 8'h02;
         repeat (4) @(posedge clk_in);
         halt(2'h0);
         wake(8);
         chk(8'(low_power_out), 8'h01);
         @(posedge clk_in);
         port_pins_in <= ~port_pins_in & 8'h01;
         wake(10);
         chk(8'(cause), 8'(PMWC_WAKE_RESUME));
         @(posedge clk_in);
         irq_req_in <= 8'h00;
      end
      halt(2'h0);
      @(posedge clk_in);
      wdt_overflow_in <= 1'b1;
      wake(10);
      chk({wrst, 4'h0, cause}, {1'b1, 4'h0, PMWC_WAKE_WDT_RESET});
      chk(8'({wdt_expiry_flag_out, power_down_flag_out}), 8'h03);
      @(posedge clk_in);
      wdt_overflow_in <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         halt(2'h0);
         @(posedge clk_in);
         if (k == 0) usb_reset_in <= 1'b1;
         else pin_reset_n_in <= 1'b0;
         wake(10);
         chk({srst, 4'h0, cause}, {1'b1, 4'h0, PMWC_WAKE_SYS_RESET});
         @(posedge clk_in);
         {usb_reset_in, pin_reset_n_in} <= 2'h1;
      end
      @(posedge clk_in);
      clr_wdt_in <= 1'b1;
      @(posedge clk_in);
      clr_wdt_in <= 1'b0;
      @(negedge clk_in);
      chk(8'(power_down_flag_out), 8'h00);
      for (int f = 0; f < 7; f++) begin
         @(posedge clk_in);
         scc_in.clock_select_field <= f[2:0];
         repeat (3) @(negedge clk_in);
         chk({gate_out.slow_sel, high_div_mask_out}, 8'((1 << f) - 1));
      end
      @(posedge clk_in);
      scc_in.sub_clock_source_select <= 1'b1;
      scc_in.clock_select_field <= PMWC_CKS_SLOW;
      repeat (4) @(negedge clk_in);
      chk(8'(gate_out.slow_sel), 8'h00);
      @(posedge clk_in);
      low_crystal_osc_stable_in <= 1'b1;
      repeat (4) @(negedge clk_in);
      chk({gate_out.slow_sel, high_div_mask_out}, 8'hBF);
      @(posedge clk_in);
      pll_enable_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      chk(8'(pll_lock_flag_out), 8'h00);
      repeat (int'(PMWC_PLL_SETTLE_CYC) + 4) @(negedge clk_in);
      chk(8'(pll_lock_flag_out), 8'h01);
      // Software returns to the undivided high clock rate only once the lock flag is seen high.
      @(posedge clk_in);
      scc_in.clock_select_field <= 3'h0;
      repeat (3) @(negedge clk_in);
      chk({gate_out.slow_sel, high_div_mask_out}, 8'h00);
      final_report;
   end
endmodule
